// File: include/skew_regs_pkg.sv
// package for the output skew control registers and their serial port
package skew_regs_pkg;

    // ==========================================================
    // serial port addressing and framing
    localparam logic [6:0] SMB_ADDR     = 7'h6A;   // D4 write, D5 read
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] PHASE_DATA0  = 8'h02;   // after command and count
    localparam logic [7:0] PHASE_MAX    = 8'hFF;
    localparam logic [7:0] READ_COUNT   = 8'h15;   // bytes 0..20 returned

    // ==========================================================
    // register indices, fields and reset values
    localparam logic [7:0] IDX_CMP_FB   = 8'h13;
    localparam logic [7:0] IDX_TRUE     = 8'h14;
    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam int         SKEW_HI      = 7;
    localparam int         SKEW_LO      = 4;
    localparam int         FB_HI        = 1;
    localparam int         FB_LO        = 0;

    // ==========================================================
    // types
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WBYTE, ST_RBYTE, ST_RACK} smb_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic filt;
    } sync_state_t;

    // skew selects and their decoded settings
    typedef struct packed {
        logic [3:0] complement_skew_sel;
        logic [3:0] true_skew_sel;
        logic [1:0] feedback_skew_sel;
        logic [9:0] complement_skew;
        logic [9:0] true_skew;
        logic [9:0] feedback_skew;
    } skew_cfg_t;

    typedef struct packed {
        smb_state_t state;
        logic [7:0] shift;
        logic [3:0] bitcnt;
        logic [7:0] phase;
        logic       rw;
        logic       scl_q;
        logic       sda_q;
        logic       sda_oe;
        logic       sda_out;
        logic [7:0] complement_and_feedback_skew;
        logic [7:0] true_output_skew;
        skew_cfg_t  skew;
    } core_state_t;

    // ==========================================================
    // seven-step skew code for the memory clock pairs
    function automatic logic [9:0] skew7_value(input logic [3:0] code);
        unique case (code)
            4'h4:    skew7_value = 10'h096;   // 150
            4'h8:    skew7_value = 10'h12C;   // 300
            4'hC:    skew7_value = 10'h1C2;   // 450
            4'hD:    skew7_value = 10'h258;   // 600
            4'hE:    skew7_value = 10'h2EE;   // 750
            4'hF:    skew7_value = 10'h384;   // 900
            default: skew7_value = 10'h000;   // 0000 and unlisted codes
        endcase
    endfunction : skew7_value

    // four-step skew code for the feedback pair
    function automatic logic [9:0] fb_value(input logic [1:0] code);
        unique case (code)
            2'h0: fb_value = 10'h000;
            2'h1: fb_value = 10'h0FA;   // 250
            2'h2: fb_value = 10'h1F4;   // 500
            2'h3: fb_value = 10'h2EE;   // 750
        endcase
    endfunction : fb_value

    function automatic logic [7:0] phase_bump(input logic [7:0] p);
        phase_bump = (p == PHASE_MAX) ? p : 8'(p + 8'h01);
    endfunction : phase_bump

endpackage : skew_regs_pkg

// File: src/pin_filter.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_filter (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // pin and filtered level
    input  wire logic pin_i,
    output logic      level_o
);
    import skew_regs_pkg::*;

    sync_state_t st_r;
    sync_state_t st_nxt;

    // ==========================================================
    // level only moves once stages two and three agree
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.filt = st_r.s3;
        end
    end

    // idle bus is high, so reset to ones to avoid a false edge
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.filt;

endmodule : pin_filter
`default_nettype wire

// File: src/output_skew_control_regs.sv
// skew configuration bytes with their block write / block read serial slave
`timescale 1ns/100ps
`default_nettype none
module output_skew_control_regs (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // serial port pins
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    // delay line controls
    output skew_regs_pkg::skew_cfg_t  skew_o
);
    import skew_regs_pkg::*;

    core_state_t st_r;
    core_state_t st_nxt;
    logic        scl;
    logic        sda;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        wr_en;
    logic [7:0]  wr_idx;
    logic [7:0]  tx_byte;

    // ==========================================================
    // pin conditioning
    pin_filter u_scl (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (scl_i),
        .level_o (scl)
    );

    pin_filter u_sda (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (sda_i),
        .level_o (sda)
    );

    // ==========================================================
    // bus events from filtered levels
    assign scl_rise  = scl & ~st_r.scl_q;
    assign scl_fall  = ~scl & st_r.scl_q;
    assign start_det = scl & st_r.scl_q & st_r.sda_q & ~sda;
    assign stop_det  = scl & st_r.scl_q & ~st_r.sda_q & sda;
    assign wr_idx    = 8'(st_r.phase - PHASE_DATA0);

    // read map: count first, then byte n at phase n+1
    always_comb begin
        tx_byte = CFG_RESET;
        if (st_r.phase == 8'h00) begin
            tx_byte = READ_COUNT;
        end else if (8'(st_r.phase - 8'h01) == IDX_CMP_FB) begin
            tx_byte = st_r.complement_and_feedback_skew;
        end else if (8'(st_r.phase - 8'h01) == IDX_TRUE) begin
            tx_byte = st_r.true_output_skew;
        end
    end

    // ==========================================================
    // protocol engine and register update
    always_comb begin
        st_nxt         = st_r;
        st_nxt.scl_q   = scl;
        st_nxt.sda_q   = sda;
        st_nxt.sda_out = 1'b0;   // open drain: only ever pulls low
        wr_en          = 1'b0;
        if (start_det) begin
            st_nxt.state  = ST_ADDR;   // repeated start also lands here
            st_nxt.bitcnt = 4'h0;
            st_nxt.phase  = 8'h00;     // always restart at phase 0, the command or count byte
            st_nxt.sda_oe = 1'b0;
        end else if (stop_det) begin
            st_nxt.state  = ST_IDLE;   // bytes already stored stay
            st_nxt.sda_oe = 1'b0;
        end else begin
            unique case (st_r.state)
                ST_IDLE: begin
                end
                ST_ADDR, ST_WBYTE: begin
                    if (scl_rise) begin
                        st_nxt.shift  = {st_r.shift[6:0], sda};
                        st_nxt.bitcnt = 4'(st_r.bitcnt + 4'h1);
                    end else if (scl_fall && st_r.bitcnt == BITS_PER_BYTE) begin
                        if (st_r.state == ST_WBYTE) begin
                            // command and count are acked but dropped
                            wr_en         = (st_r.phase >= PHASE_DATA0);
                            st_nxt.phase  = phase_bump(st_r.phase);
                            st_nxt.sda_oe = 1'b1;
                            st_nxt.state  = ST_ACK;
                        end else if (st_r.shift[7:1] == SMB_ADDR) begin
                            st_nxt.rw     = st_r.shift[0];
                            st_nxt.sda_oe = 1'b1;
                            st_nxt.state  = ST_ACK;
                        end else begin
                            st_nxt.state  = ST_IDLE;   // not ours, stay off
                        end
                    end
                end
                ST_ACK: begin
                    // ack bit ends on the falling edge
                    if (scl_fall) begin
                        st_nxt.bitcnt = 4'h0;
                        if (st_r.rw) begin
                            st_nxt.shift  = tx_byte;
                            st_nxt.sda_oe = ~tx_byte[7];
                            st_nxt.phase  = phase_bump(st_r.phase);
                            st_nxt.state  = ST_RBYTE;
                        end else begin
                            st_nxt.sda_oe = 1'b0;
                            st_nxt.state  = ST_WBYTE;
                        end
                    end
                end
                ST_RBYTE: begin
                    if (scl_rise) begin
                        st_nxt.bitcnt = 4'(st_r.bitcnt + 4'h1);
                    end else if (scl_fall) begin
                        if (st_r.bitcnt == BITS_PER_BYTE) begin
                            st_nxt.sda_oe = 1'b0;   // let the host ack
                            st_nxt.state  = ST_RACK;
                        end else begin
                            st_nxt.shift  = {st_r.shift[6:0], 1'b0};
                            st_nxt.sda_oe = ~st_r.shift[6];
                        end
                    end
                end
                ST_RACK: begin
                    // a nack ends the read; the host then sends stop
                    if (scl_rise) begin
                        st_nxt.state = sda ? ST_IDLE : ST_ACK;
                    end
                end
                default: begin
                    st_nxt.state  = ST_IDLE;
                    st_nxt.sda_oe = 1'b0;
                end
            endcase
        end
        // only the two skew bytes hold storage; other indices are dropped
        if (wr_en && wr_idx == IDX_CMP_FB) begin
            st_nxt.complement_and_feedback_skew = st_r.shift;   // reserved 3:2 kept
        end
        if (wr_en && wr_idx == IDX_TRUE) begin
            st_nxt.true_output_skew = st_r.shift;   // reserved 3:0 kept
        end
        // decoded from next value so outputs stay registered
        st_nxt.skew.complement_skew_sel =
            st_nxt.complement_and_feedback_skew[SKEW_HI:SKEW_LO];
        st_nxt.skew.true_skew_sel       = st_nxt.true_output_skew[SKEW_HI:SKEW_LO];
        st_nxt.skew.feedback_skew_sel   =
            st_nxt.complement_and_feedback_skew[FB_HI:FB_LO];
        st_nxt.skew.complement_skew     =
            skew7_value(st_nxt.complement_and_feedback_skew[SKEW_HI:SKEW_LO]);
        st_nxt.skew.true_skew           =
            skew7_value(st_nxt.true_output_skew[SKEW_HI:SKEW_LO]);
        st_nxt.skew.feedback_skew       =
            fb_value(st_nxt.complement_and_feedback_skew[FB_HI:FB_LO]);
    end

    // all-zero reset gives zero skew and idle bus
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r       <= '0;
            st_r.scl_q <= 1'b1;   // idle bus levels, so no false edge after reset
            st_r.sda_q <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sda_o    = st_r.sda_out;
    assign sda_oe_o = st_r.sda_oe;
    assign skew_o   = st_r.skew;

    // ==========================================================
    // checks
    cmp_skew_map_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        skew_o.complement_skew ==
            skew7_value(st_r.complement_and_feedback_skew[SKEW_HI:SKEW_LO]))
        else $error("complement skew does not match byte 19");

    true_skew_map_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        skew_o.true_skew == skew7_value(skew_o.true_skew_sel))
        else $error("true skew does not match its select");

    fb_skew_map_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        skew_o.feedback_skew == fb_value(st_r.complement_and_feedback_skew[FB_HI:FB_LO]))
        else $error("feedback skew does not match byte 19");

    reset_zero_a: assert property (
        @(posedge clk_i)
        $rose(rst_n_i) |-> (st_r.complement_and_feedback_skew == CFG_RESET
                            && st_r.true_output_skew == CFG_RESET
                            && skew_o.complement_skew == 10'h000 && !sda_oe_o))
        else $error("skew bytes not zero after reset");

    full_byte_store_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && wr_idx == IDX_TRUE) |=> st_r.true_output_skew == $past(st_r.shift))
        else $error("byte 20 not stored whole");

    addr_ack_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_r.state == ST_ADDR && scl_fall && st_r.bitcnt == BITS_PER_BYTE
         && st_r.shift[7:1] == SMB_ADDR && !start_det && !stop_det)
        |=> (sda_oe_o && st_r.state == ST_ACK))
        else $error("own address not acknowledged");

    read_release_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_r.state == ST_RACK) |-> !sda_oe_o)
        else $error("device drives data line during host ack");

    stop_idle_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (stop_det && !start_det) |=> (st_r.state == ST_IDLE && !sda_oe_o))
        else $error("stop did not return to idle");

    write_cfg_c: cover property (
        @(posedge clk_i) disable iff (!rst_n_i) wr_en && wr_idx == IDX_CMP_FB);
    read_byte_c: cover property (
        @(posedge clk_i) disable iff (!rst_n_i) st_r.state == ST_RACK ##[1:400] scl_rise && !sda);
    max_skew_c: cover property (
        @(posedge clk_i) disable iff (!rst_n_i) skew_o.true_skew_sel == 4'hF);
    restart_c: cover property (
        @(posedge clk_i) disable iff (!rst_n_i) start_det && st_r.state == ST_WBYTE);

endmodule : output_skew_control_regs
`default_nettype wire

// File: sim/smb_host_model.sv
// serial host model that clocks the bus and pulls the data line low
`timescale 1ns/100ps
`default_nettype none
module smb_host_model #(
    parameter int HALF = 8
) (
    // clock
    input  wire logic       clk_i,
    // resolved data line, pulled up
    input  wire logic       sda_line_i,
    // bus drive, clock is push-pull from the host alone
    output logic            scl_o,
    output logic            sda_oe_o,
    // bytes returned by the device
    output logic [7:0]      rd_data_o,
    output logic            rd_stb_o
);
    // ==========================================
    // idle bus: clock high, data left to its pull-up
    initial begin
        scl_o     = 1'b1;
        sda_oe_o  = 1'b0;
        rd_data_o = 8'h00;
        rd_stb_o  = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_clk

    // data moves only mid-low so the device filters never see it race the clock
    task automatic bit_xfer(input logic b, output logic r);
        wait_clk(HALF);
        sda_oe_o <= ~b;
        wait_clk(HALF);
        scl_o    <= 1'b1;
        wait_clk(HALF);
        r = sda_line_i;
        scl_o    <= 1'b0;
    endtask : bit_xfer

    // start also serves as repeated start: release data before raising clock
    task automatic start_cond();
        wait_clk(HALF);
        sda_oe_o <= 1'b0;
        wait_clk(HALF);
        scl_o    <= 1'b1;
        wait_clk(HALF);
        sda_oe_o <= 1'b1;
        wait_clk(HALF);
        scl_o    <= 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        wait_clk(HALF);
        sda_oe_o <= 1'b1;
        wait_clk(HALF);
        scl_o    <= 1'b1;
        wait_clk(HALF);
        sda_oe_o <= 1'b0;
        wait_clk(HALF);
    endtask : stop_cond

    // eight bits msb first, then the ninth bit; ack is high when the line was low
    task automatic xfer_byte(input logic [7:0] wd, input logic nine, input logic is_rd,
                             output logic [7:0] rd, output logic ack);
        int i;
        for (i = 7; i >= 0; i--) begin
            bit_xfer(wd[i], rd[i]);
        end
        bit_xfer(nine, ack);
        ack = ~ack;
        if (is_rd) begin
            rd_data_o <= rd;
            rd_stb_o  <= 1'b1;
            @(posedge clk_i);
            rd_stb_o  <= 1'b0;
        end
    endtask : xfer_byte
endmodule : smb_host_model
`default_nettype wire

// File: sim/output_skew_control_regs_bench.sv
// self-checking bench for the skew configuration bytes and their serial port
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module output_skew_control_regs_bench;
    import skew_regs_pkg::*;
    // ==========================================
    // signals and expectations
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       scl, host_oe, sda_o, sda_oe_o, sda_line, rd_stb;
    logic [7:0] rd_data, want, cur19 = 8'h00, cur20 = 8'h00;
    skew_cfg_t  skew_o;
    logic [7:0] img [0:20];
    logic [7:0] exp_q [$];
    logic [3:0] codes [0:6] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'hD, 4'hE, 4'hF};
    logic [9:0] set7 [0:6] = '{10'h000, 10'h096, 10'h12C, 10'h1C2, 10'h258, 10'h2EE, 10'h384};
    logic [9:0] set4 [0:3] = '{10'h000, 10'h0FA, 10'h1F4, 10'h2EE};
    int         failures = 0, n_tests = 0, seed = 32'h0000_a54d;

    always #5 clk_i = ~clk_i;
    // open-drain data line with pull-up
    assign sda_line = ~(host_oe | (sda_oe_o & ~sda_o));

    output_skew_control_regs uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .skew_o(skew_o));
    smb_host_model #(.HALF(8)) host (.clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl),
        .sda_oe_o(host_oe), .rd_data_o(rd_data), .rd_stb_o(rd_stb));

    // ==========================================
    // tasks
    task automatic check_skew(input int c, input int t, input int f);
        `CHK(skew_o.complement_skew_sel, codes[c])
        `CHK(skew_o.complement_skew, set7[c])
        `CHK(skew_o.true_skew_sel, codes[t])
        `CHK(skew_o.true_skew, set7[t])
        `CHK(skew_o.feedback_skew_sel, 2'(f))
        `CHK(skew_o.feedback_skew, set4[f])
    endtask : check_skew

    task automatic write_cfg(input logic [7:0] adr, input int n, output logic ack0);
        logic [7:0] rd;
        logic       ak;
        int         k;
        host.start_cond();
        host.xfer_byte(adr, 1'b1, 1'b0, rd, ack0);
        if (ack0) begin
            host.xfer_byte(8'($random(seed)), 1'b1, 1'b0, rd, ak); // command ignored
            host.xfer_byte(8'($random(seed)), 1'b1, 1'b0, rd, ak); // count ignored
            for (k = 0; k < n; k++) begin
                host.xfer_byte(img[k], 1'b1, 1'b0, rd, ak);
                `CHK(ak, 1'b1)
            end
            if (n > 19) cur19 = img[19];
            if (n > 20) cur20 = img[20];
        end
        host.stop_cond();
    endtask : write_cfg

    task automatic read_cfg(input int n);
        logic [7:0] rd;
        logic       ak;
        int         k;
        host.start_cond();
        host.xfer_byte(8'hD5, 1'b1, 1'b0, rd, ak);
        `CHK(ak, 1'b1)
        exp_q.push_back(READ_COUNT);
        host.xfer_byte(8'hFF, 1'b0, 1'b1, rd, ak);
        for (k = 0; k < n; k++) begin
            exp_q.push_back(k == 19 ? cur19 : (k == 20 ? cur20 : 8'h00));
            host.xfer_byte(8'hFF, (k == n - 1), 1'b1, rd, ak); // last one refused
        end
        host.stop_cond();
    endtask : read_cfg

    task automatic end_sim();
        // a note that never met its byte is a lost answer
        if (exp_q.size() != 0) begin
            failures++;
            $display("wrong value at %0t: %0d notes never answered", $time, exp_q.size());
        end
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // ==========================================
    // returned bytes against the oldest note
    always @(posedge clk_i) begin
        if (rd_stb) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("wrong value at %0t: byte with no note", $time);
            end else begin
                want = exp_q.pop_front();
                `CHK(rd_data, want)
            end
        end
    end

    // hang guard, well above the roughly 75k cycles of the sequence
    initial begin
        repeat (100000) @(posedge clk_i);
        failures++;
        end_sim();
    end

    // ==========================================
    // main sequence
    initial begin
        logic [7:0] rd;
        logic ak;
        int   c;
        for (c = 0; c < 21; c++) img[c] = 8'h00; // other bytes resent unaltered
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check_skew(0, 0, 0);
        read_cfg(21);
        // every code on both pairs, random reserved bits
        for (c = 0; c < 7; c++) begin
            img[19] = {codes[c], 2'($random(seed)), 2'(c % 4)};
            img[20] = {codes[6 - c], 4'($random(seed))};
            write_cfg(8'hD4, 21, ak);
            check_skew(c, 6 - c, c % 4);
            if (c % 3 == 0) read_cfg(21);
        end
        // transfer stopped after byte 19 leaves byte 20 alone
        img[19] = {codes[1], 4'h5};
        img[20] = 8'hFF;
        write_cfg(8'hD4, 20, ak);
        check_skew(1, 0, 1);
        // a foreign address is neither acked nor stored
        img[19] = 8'hF3;
        write_cfg(8'hD6, 21, ak);
        `CHK(ak, 1'b0)
        check_skew(1, 0, 1);
        // unlisted codes keep their raw select but give zero setting
        img[19] = 8'h12;
        img[20] = 8'h3C;
        write_cfg(8'hD4, 21, ak);
        `CHK(skew_o.complement_skew_sel, 4'h1)
        `CHK(skew_o.complement_skew, 10'h000)
        `CHK(skew_o.true_skew_sel, 4'h3)
        `CHK(skew_o.true_skew, 10'h000)
        `CHK(skew_o.feedback_skew, set4[2])
        // repeated start after a write header reads from the count again
        host.start_cond();
        host.xfer_byte(8'hD4, 1'b1, 1'b0, rd, ak);
        host.xfer_byte(8'($random(seed)), 1'b1, 1'b0, rd, ak);
        host.start_cond();
        host.xfer_byte(8'hD5, 1'b1, 1'b0, rd, ak);
        `CHK(ak, 1'b1)
        exp_q.push_back(READ_COUNT);
        host.xfer_byte(8'hFF, 1'b1, 1'b1, rd, ak); // refused at once
        host.stop_cond();
        read_cfg(3);
        read_cfg(21);
        end_sim();
    end
endmodule : output_skew_control_regs_bench
`undef CHK
`default_nettype wire
